/* core/ubm_defines.svh */
/*
 * Constants of the shared USB host buffer memory: address map, index
 * arithmetic, descriptor geometry. Assumes it is included by bare name.
 */
`ifndef UBM_DEFINES_SVH
`define UBM_DEFINES_SVH

`define UBM_REG_TOP        16'h03FF
`define UBM_MEM_BASE       16'h0400
`define UBM_DESC_LAST      16'h0FFF
`define UBM_PAYLOAD_BASE   16'h1000
`define UBM_ISO_BASE       16'h0400
`define UBM_INT_BASE       16'h0800
`define UBM_ASYNC_BASE     16'h0C00
`define UBM_IDX_SHIFT      3
`define UBM_IDX_W          13
`define UBM_DESC_COUNT     32
`define UBM_DESC_DWORDS    8
`define UBM_DESC_IDX_BITS  2
`define UBM_SLOT_W         5
`define UBM_PRIO_CPU       1'b0
`define UBM_PRIO_ENG       1'b1

`endif

/* core/ubm_pkg.sv */
/*
 * Types of the shared USB host buffer memory. Assumes the defines header
 * is compiled alongside; holds no numbers of its own.
 */
package ubm_pkg;
	// Address region seen by the processor
	typedef enum logic [2:0]
	{
		UBM_RGN_REG = 3'b000,
		UBM_RGN_ISO = 3'b001,
		UBM_RGN_INT = 3'b011,
		UBM_RGN_ASY = 3'b010,
		UBM_RGN_PAY = 3'b110
	} ubm_region_t;

	// Arbiter states, Gray along idle -> cpu -> engine
	typedef enum logic [1:0]
	{
		UBM_ARB_IDLE = 2'b00,
		UBM_ARB_CPU  = 2'b01,
		UBM_ARB_ENG  = 2'b11
	} ubm_arb_t;
endpackage

/* core/ubm_ram.sv */
/*
 * Single-port 64-bit buffer memory with per-dword write enables.
 * Assumes one requester at a time, chosen by the arbiter above it.
 */
`timescale 1ns/100ps
`include "ubm_defines.svh"

module ubm_ram
#(
	parameter int IDX_W = `UBM_IDX_W
)
(
	// Clock
	input  wire logic              ref_clk,
	// Access port
	input  wire logic              en,
	input  wire logic [1:0]        we,
	input  wire logic [IDX_W-1:0]  idx,
	input  wire logic [63:0]       wdata,
	output logic      [63:0]       rdata_q
);
	logic [63:0] mem [0:(1<<IDX_W)-1];

	// Synchronous read; each dword lane writes on its own enable
	always_ff @(posedge ref_clk)
	begin
		if (en && we[0])
			mem[idx][31:0] <= wdata[31:0];
		if (en && we[1])
			mem[idx][63:32] <= wdata[63:32];
		if (en)
			rdata_q <= mem[idx];
	end
endmodule

/* core/ubm_buffer_mem.sv */
/*
 * Shared buffer memory of the slave USB host controller: decodes the
 * processor's byte address, forms the 64-bit word index, arbitrates
 * processor and host engine, and raises the completion interrupt.
 * Assumes the processor holds a request until ack, and the engine does
 * likewise; both are synchronous to ref_clk.
 */
// How it works
// - The lowest 1 kbyte of the 64 kbyte space is register space, not buffer memory.
// - Addresses 0400h to 0FFFh are descriptor areas for iso, interrupt and async lists.
// - Addresses 1000h to FFFFh are the payload region.
// - Memory index is (address - 0400h) >> 3, payload landing at 0180h to 1F7Fh.
// - Each list holds up to 32 descriptors, each with its own payload.
// - A descriptor is eight dwords with one layout for all list types.
// - Every buffer access is dword aligned.
// - An arbiter shares the 64-bit memory between processor and engine.
// - Processor updates to one descriptor proceed while the engine runs another.
// - Descriptor completion raises an interrupt request.
// - The interrupt pin follows the OR-type and AND-type masks.
// - After reset the root port reports a new connection of the internal hub.
// - The three downstream ports always route through the internal hub.
// - A low level on reset_n requests reset.
`timescale 1ns/100ps
`include "ubm_defines.svh"

module ubm_buffer_mem
#(
	parameter int IDX_W = `UBM_IDX_W
)
(
	// Clock and reset
	input  wire logic              ref_clk,
	input  wire logic              reset_n,
	// Processor port (byte address, one dword per access)
	input  wire logic              cpu_req,
	input  wire logic              cpu_we,
	input  wire logic [15:0]       cpu_addr,
	input  wire logic [31:0]       cpu_wdata,
	output logic                   cpu_ack_q,
	output logic                   cpu_err_q,
	output logic      [31:0]       cpu_rdata_q,
	output logic      [2:0]        cpu_region_q,
	// Host engine port (64-bit word index)
	input  wire logic              eng_req,
	input  wire logic              eng_we,
	input  wire logic [IDX_W-1:0]  eng_idx,
	input  wire logic [63:0]       eng_wdata,
	output logic                   eng_ack_q,
	output logic      [63:0]       eng_rdata_q,
	// Descriptor completion from the engine
	input  wire logic              done_pulse,
	input  wire logic [1:0]        done_list,
	input  wire logic [4:0]        done_slot,
	// Interrupt qualification
	input  wire logic [2:0]        irq_or_mask,
	input  wire logic [2:0]        irq_and_mask,
	input  wire logic              irq_clear,
	output logic                   irq_q,
	output logic      [2:0]        irq_status_q,
	// Root port and hub routing status
	output logic                   root_connect_q,
	output logic      [2:0]        port_via_hub_q
);
	// Processor address decode
	wire        in_regs    = (cpu_addr <= `UBM_REG_TOP);
	wire        is_pay     = (cpu_addr >= `UBM_PAYLOAD_BASE);
	wire        is_desc    = !in_regs && !is_pay;
	wire        is_iso     = is_desc && (cpu_addr < `UBM_INT_BASE);
	wire        is_int     = is_desc && (cpu_addr >= `UBM_INT_BASE)
	                         && (cpu_addr < `UBM_ASYNC_BASE);
	wire        is_asy     = is_desc && (cpu_addr >= `UBM_ASYNC_BASE);
	wire        misalign   = |cpu_addr[1:0];
	wire        cpu_bad    = in_regs || misalign;
	ubm_pkg::ubm_region_t region;
	assign region = is_pay ? ubm_pkg::UBM_RGN_PAY :
	                is_asy ? ubm_pkg::UBM_RGN_ASY :
	                is_int ? ubm_pkg::UBM_RGN_INT :
	                is_iso ? ubm_pkg::UBM_RGN_ISO : ubm_pkg::UBM_RGN_REG;

	// Byte address to 64-bit word index: a descriptor's eight dwords fill four words
	function automatic logic [IDX_W-1:0] word_index(input logic [15:0] a);
		logic [15:0] off;
		off = a - `UBM_MEM_BASE;
		word_index = IDX_W'(off >> `UBM_IDX_SHIFT);
	endfunction

	wire [IDX_W-1:0] cpu_idx  = word_index(cpu_addr);
	wire             cpu_hi   = cpu_addr[2]; // Upper dword of the 64-bit word

	// Arbiter state
	ubm_pkg::ubm_arb_t st_q, st_d;
	logic              last_q; // Who was served last, for fairness
	logic              last_d;
	wire               cpu_ok   = cpu_req && !cpu_bad && !cpu_ack_q;
	wire               eng_ok   = eng_req && !eng_ack_q;
	wire               pick_eng = eng_ok && (!cpu_ok || last_q == `UBM_PRIO_CPU);

	// Grant only from idle, so each access completes before the next grant
	always_comb
	begin
		st_d   = ubm_pkg::UBM_ARB_IDLE;
		last_d = last_q;
		case (st_q)
			ubm_pkg::UBM_ARB_IDLE:
			begin
				if (pick_eng)
				begin
					st_d   = ubm_pkg::UBM_ARB_ENG;
					last_d = `UBM_PRIO_ENG;
				end
				else if (cpu_ok)
				begin
					st_d   = ubm_pkg::UBM_ARB_CPU;
					last_d = `UBM_PRIO_CPU;
				end
			end
			ubm_pkg::UBM_ARB_CPU: st_d = ubm_pkg::UBM_ARB_IDLE;
			ubm_pkg::UBM_ARB_ENG: st_d = ubm_pkg::UBM_ARB_IDLE;
			default:              st_d = ubm_pkg::UBM_ARB_IDLE;
		endcase
	end

	// Memory port selection: issued in the cycle of the idle decision
	wire             go_cpu  = (st_q == ubm_pkg::UBM_ARB_IDLE) && !pick_eng && cpu_ok;
	wire             go_eng  = (st_q == ubm_pkg::UBM_ARB_IDLE) && pick_eng;
	wire             ram_en  = go_cpu || go_eng;
	wire [1:0]       ram_we  = go_eng ? {eng_we, eng_we} :
	                           (go_cpu && cpu_we) ? {cpu_hi, !cpu_hi} : 2'b00;
	wire [IDX_W-1:0] ram_idx = go_eng ? eng_idx : cpu_idx;
	wire [63:0]      ram_wd  = go_eng ? eng_wdata : {cpu_wdata, cpu_wdata};
	wire [63:0]      ram_rd;

	// Lane-wise writes keep the other dword intact, so on-the-fly updates are safe
	ubm_ram #(.IDX_W(IDX_W)) u_ram
	(
		.ref_clk (ref_clk),
		.en      (ram_en),
		.we      (ram_we),
		.idx     (ram_idx),
		.wdata   (ram_wd),
		.rdata_q (ram_rd)
	);

	// Remember which dword the processor asked for
	logic cpu_hi_q;

	// Arbiter registers
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			st_q     <= ubm_pkg::UBM_ARB_IDLE;
			last_q   <= `UBM_PRIO_ENG;
			cpu_hi_q <= 1'b0;
		end
		else
		begin
			st_q     <= st_d;
			last_q   <= last_d;
			if (go_cpu)
				cpu_hi_q <= cpu_hi;
		end
	end

	// Answers: ack one cycle after the grant, data from the RAM
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			cpu_ack_q    <= 1'b0;
			cpu_err_q    <= 1'b0;
			cpu_rdata_q  <= 32'h0000_0000;
			cpu_region_q <= 3'h0;
			eng_ack_q    <= 1'b0;
			eng_rdata_q  <= 64'h0000_0000_0000_0000;
		end
		else
		begin
			// Bad accesses are refused at once and never reach memory
			cpu_err_q    <= cpu_req && cpu_bad && !cpu_err_q && !cpu_ack_q;
			cpu_ack_q    <= (st_q == ubm_pkg::UBM_ARB_CPU)
			                || (cpu_req && cpu_bad && !cpu_err_q && !cpu_ack_q);
			cpu_region_q <= region;
			eng_ack_q    <= (st_q == ubm_pkg::UBM_ARB_ENG);
			if (st_q == ubm_pkg::UBM_ARB_CPU)
				cpu_rdata_q <= cpu_hi_q ? ram_rd[63:32] : ram_rd[31:0];
			if (st_q == ubm_pkg::UBM_ARB_ENG)
				eng_rdata_q <= ram_rd;
		end
	end

	// Completion flags per list; slot above 31 cannot occur with 5 bits
	wire [2:0] done_vec = done_pulse ? (3'b001 << done_list) : 3'b000;
	wire [2:0] stat_d   = (irq_clear ? 3'b000 : irq_status_q) | done_vec;
	wire       or_hit   = |(stat_d & irq_or_mask);
	wire       and_hit  = (|irq_and_mask) && ((stat_d & irq_and_mask) == irq_and_mask);

	// Set wins over clear so a completion at the clear is not lost
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			irq_status_q <= 3'h0;
			irq_q        <= 1'b0;
		end
		else
		begin
			irq_status_q <= stat_d;
			irq_q        <= or_hit || and_hit;
		end
	end

	// Internal hub is always attached: connection shows from the first clock
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			root_connect_q <= 1'b0;
			port_via_hub_q <= 3'h0;
		end
		else
		begin
			root_connect_q <= 1'b1;
			port_via_hub_q <= 3'h7;
		end
	end
endmodule

/* tb/ubm_asserts.sv */
/*
 * Port checker of the shared buffer memory, bound to every instance.
 * Assumes the processor and engine hold requests until their ack.
 */
`timescale 1ns/100ps
module ubm_asserts
(
	// Clock and reset
	input wire logic        ref_clk,
	input wire logic        reset_n,
	// Processor side
	input wire logic        cpu_req,
	input wire logic [15:0] cpu_addr,
	input wire logic        cpu_ack_q,
	input wire logic        cpu_err_q,
	input wire logic [2:0]  cpu_region_q,
	// Engine, completion and status
	input wire logic        eng_req,
	input wire logic        eng_ack_q,
	input wire logic        done_pulse,
	input wire logic [1:0]  done_list,
	input wire logic [2:0]  irq_or_mask,
	input wire logic [2:0]  irq_and_mask,
	input wire logic        irq_q,
	input wire logic [2:0]  irq_status_q,
	input wire logic        root_connect_q,
	input wire logic [2:0]  port_via_hub_q
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	// Expected region of a byte address
	function automatic logic [2:0] rgn(input logic [15:0] a);
		rgn = (a < 16'h0400) ? 3'b000 : (a < 16'h0800) ? 3'b001 :
			(a < 16'h0C00) ? 3'b011 : (a < 16'h1000) ? 3'b010 : 3'b110;
	endfunction
	// Level the pin should show for the present flags and masks
	wire logic irq_want = |(irq_status_q & irq_or_mask) ||
		(|irq_and_mask && ((irq_status_q & irq_and_mask) == irq_and_mask));
	reg_space_a: assert property (cpu_ack_q && cpu_addr < 16'h0400 |-> cpu_err_q)
		else $error("register space access not refused");
	dword_align_a: assert property (cpu_ack_q && cpu_addr[1:0] != 2'b00 |-> cpu_err_q)
		else $error("misaligned access not refused");
	mem_access_a: assert property (cpu_ack_q && cpu_addr >= 16'h0400 && cpu_addr[1:0] == 2'b00
		|-> !cpu_err_q) else $error("buffer access refused");
	region_dec_a: assert property ($past(reset_n) |-> cpu_region_q == rgn($past(cpu_addr)))
		else $error("region decode wrong");
	ack_once_a: assert property (cpu_ack_q |=> !cpu_ack_q)
		else $error("processor ack longer than one cycle");
	cpu_served_a: assert property ($rose(cpu_req) |-> ##[1:5] cpu_ack_q)
		else $error("processor starved");
	eng_served_a: assert property ($rose(eng_req) |-> ##[1:5] eng_ack_q)
		else $error("engine starved");
	done_flag_a: assert property (done_pulse && done_list != 2'd3
		|=> irq_status_q[$past(done_list)]) else $error("completion flag missing");
	irq_mask_a: assert property ($past(reset_n) && $stable(irq_or_mask) && $stable(irq_and_mask)
		&& $stable(irq_status_q) |-> irq_q == irq_want) else $error("irq qualify");
	root_hub_a: assert property ($past(reset_n) |-> root_connect_q && port_via_hub_q == 3'b111)
		else $error("root port or hub routing wrong");
	// Main scenarios
	cover property (cpu_ack_q && cpu_err_q);
	cover property (cpu_req && eng_req);
	cover property (irq_q);
endmodule
bind ubm_buffer_mem ubm_asserts chk
(
	.ref_clk, .reset_n, .cpu_req, .cpu_addr, .cpu_ack_q, .cpu_err_q, .cpu_region_q,
	.eng_req, .eng_ack_q, .done_pulse, .done_list, .irq_or_mask, .irq_and_mask,
	.irq_q, .irq_status_q, .root_connect_q, .port_via_hub_q
);

/* tb/ubm_cpu_model.sv */
/*
 * Processor model: one held dword access at a time on the processor port.
 * Assumes ref_clk from the bench; requests change on the falling edge.
 */
`timescale 1ns/100ps
module ubm_cpu_model
(
	// Clock
	input  wire logic        ref_clk,
	// Request toward the memory
	output logic             cpu_req,
	output logic             cpu_we,
	output logic [15:0]      cpu_addr,
	output logic [31:0]      cpu_wdata,
	// Answer from the memory
	input  wire logic        cpu_ack_q,
	input  wire logic        cpu_err_q,
	input  wire logic [31:0] cpu_rdata_q
);
	initial
	begin
		cpu_req = 1'b0;
		cpu_we = 1'b0;
		cpu_addr = 16'h0000;
		cpu_wdata = 32'h0000_0000;
	end
	// Hold everything until ack is sampled high, then show inverted junk
	task automatic xfer(input logic we, input logic [15:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic er, output logic tmo);
		int n;
		@(negedge ref_clk);
		cpu_req <= 1'b1;
		cpu_we <= we;
		cpu_addr <= a;
		cpu_wdata <= wd;
		for (n = 0; n < 8 && cpu_ack_q !== 1'b1; n++) @(posedge ref_clk);
		tmo = (cpu_ack_q !== 1'b1);
		rd = cpu_rdata_q;
		er = cpu_err_q;
		@(negedge ref_clk);
		cpu_req <= 1'b0;
		cpu_addr <= ~a;
		cpu_wdata <= ~wd;
	endtask
endmodule

/* tb/tb_top.sv */
/*
 * Self-checking bench of the shared buffer memory: decode, index, sharing
 * and completion flags. Assumes the processor model and the bound checker.
 */
`timescale 1ns/100ps
module tb_top;
	logic ref_clk = 1'b0, reset_n = 1'b0, cpu_req, cpu_we, cpu_ack_q, cpu_err_q, er, to;
	logic [15:0] cpu_addr, a;
	logic [31:0] cpu_wdata, cpu_rdata_q, rd, lf = 32'h7871;
	logic [2:0] cpu_region_q, irq_or_mask = 3'b010, irq_and_mask = 3'b101, irq_status_q, st;
	logic eng_req = 1'b0, eng_we = 1'b0, eng_ack_q, done_pulse = 1'b0, irq_clear = 1'b0;
	logic irq_q, root_connect_q;
	logic [2:0] port_via_hub_q;
	logic [12:0] eng_idx = 13'h0000, k;
	logic [63:0] eng_wdata = 64'h0000_0000_0000_0000, eng_rdata_q, v, rw;
	logic [1:0] done_list = 2'd0;
	logic [4:0] done_slot = 5'h00;
	logic [15:0] edg [8] = '{16'h0400, 16'h07FC, 16'h0800, 16'h0BFC,
		16'h0C00, 16'h0FFC, 16'h1000, 16'hFFFC};
	int err_total = 0, checks_done = 0, i;
	// Free-running 100 MHz clock
	always #5 ref_clk = ~ref_clk;
	ubm_cpu_model cpu (.ref_clk, .cpu_req, .cpu_we, .cpu_addr, .cpu_wdata,
		.cpu_ack_q, .cpu_err_q, .cpu_rdata_q);
	ubm_buffer_mem dut (.ref_clk, .reset_n, .cpu_req, .cpu_we, .cpu_addr, .cpu_wdata,
		.cpu_ack_q, .cpu_err_q, .cpu_rdata_q, .cpu_region_q, .eng_req, .eng_we, .eng_idx,
		.eng_wdata, .eng_ack_q, .eng_rdata_q, .done_pulse, .done_list, .done_slot,
		.irq_or_mask, .irq_and_mask, .irq_clear, .irq_q, .irq_status_q,
		.root_connect_q, .port_via_hub_q);
	// Random source; a Galois step keeps it cheap and repeatable
	function automatic logic [31:0] nxt(input logic [31:0] s);
		nxt = {s[30:0], 1'b0} ^ (s[31] ? 32'h0040_0007 : 32'h0000_0000);
	endfunction
	function automatic logic [12:0] idx_of(input logic [15:0] b);
		idx_of = 13'((b - 16'h0400) >> 3);
	endfunction
	task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			err_total++;
			$display("unexpected %s: expected %h seen %h", nm, exp, seen);
		end
	endtask
	// Engine access, held until ack like the processor's
	task automatic eng(input logic we, input logic [12:0] x, input logic [63:0] w,
		output logic [63:0] r);
		int n;
		@(negedge ref_clk);
		eng_req <= 1'b1;
		eng_we <= we;
		eng_idx <= x;
		eng_wdata <= w;
		for (n = 0; n < 8 && eng_ack_q !== 1'b1; n++) @(posedge ref_clk);
		chk("eng_ack", eng_ack_q, 1);
		if (eng_ack_q !== 1'b1)
			test_done();
		r = eng_rdata_q;
		@(negedge ref_clk);
		eng_req <= 1'b0;
		eng_wdata <= ~w;
	endtask
	// Completion pulse, optionally with a clear in the same cycle
	task automatic done(input logic [1:0] l, input logic clr);
		@(negedge ref_clk);
		done_pulse = 1'b1;
		done_list = l;
		done_slot = lf[4:0];
		irq_clear = clr;
		@(negedge ref_clk);
		done_pulse = 1'b0;
		irq_clear = 1'b0;
		@(negedge ref_clk);
		st = (clr ? 3'b000 : st) | (3'b001 << l);
		chk("irq_status", irq_status_q, st);
		chk("irq", irq_q, |(st & irq_or_mask) || (st & irq_and_mask) == irq_and_mask);
	endtask
	task automatic test_done;
		$display("checks %0d errors %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// Main sequence
	initial
	begin
		repeat (5) @(negedge ref_clk);
		chk("reset", {cpu_ack_q, irq_q, root_connect_q, port_via_hub_q, irq_status_q}, 0);
		reset_n = 1'b1;
		repeat (2) @(negedge ref_clk);
		chk("hub", {root_connect_q, port_via_hub_q}, 4'hF);
		for (i = 0; i < 3; i++)
		begin
			cpu.xfer(1'b1, (i == 0) ? 16'h0000 : (i == 1) ? 16'h03FC : 16'h0402, lf, rd, er, to);
			chk("refused", {to, er}, 2'b01);
			if (to)
				test_done();
		end
		// One async list descriptor: eight dwords, reserved top byte left zero
		for (i = 0; i < 8; i++)
		begin
			lf = nxt(lf);
			cpu.xfer(1'b1, 16'h0C00 + 16'(i * 4), {8'h00, lf[23:0]}, rd, er, to);
			if (to)
				test_done();
			v = i[0] ? {8'h00, lf[23:0], v[31:0]} : {32'h0000_0000, 8'h00, lf[23:0]};
			if (i[0])
			begin
				eng(1'b0, idx_of(16'h0C00) + 13'(i / 2), 64'h0000_0000_0000_0000, rw);
				chk("descriptor", rw, v);
			end
		end
		for (i = 0; i < 28; i++)
		begin
			lf = nxt(lf);
			a = (i < 8) ? edg[i] : {lf[15:2], 2'b00} | 16'h0400;
			k = idx_of(a);
			v = {lf, ~lf};
			eng(1'b1, k, v, rw);
			cpu.xfer(1'b0, a, 32'h0000_0000, rd, er, to);
			chk("read", {to, er, rd}, {2'b00, a[2] ? v[63:32] : v[31:0]});
			if (to)
				test_done();
			lf = nxt(lf);
			fork
				cpu.xfer(1'b1, a, lf, rd, er, to);
				eng(1'b1, k ^ 13'h0001, ~v, rw);
			join
			chk("write", {to, er}, 2'b00);
			if (to)
				test_done();
			eng(1'b0, k, 64'h0000_0000_0000_0000, rw);
			chk("word", rw, a[2] ? {lf, v[31:0]} : {v[63:32], lf});
		end
		st = 3'b000;
		done(2'd0, 1'b0);
		done(2'd2, 1'b0);
		done(2'd1, 1'b1);
		test_done();
	end
endmodule
